// ===== src/srbc_regs.vh
`ifndef SRBC_REGS_VH
`define SRBC_REGS_VH
// ==========================================================
// Register byte offsets
`define SRBC_OFS_REFRESH_CTRL 8'h00
`define SRBC_OFS_DRAM_ACCESS 8'h04
`define SRBC_OFS_BUS_CTRL 8'h08
`define SRBC_OFS_WAIT_CTRL_B 8'h0c
`define SRBC_OFS_STANDBY_CTRL 8'h10
`define SRBC_OFS_STATUS 8'h14
// ==========================================================
// Field positions
`define SRBC_RFSH_EN_BIT 0
`define SRBC_PRE_EXT_LSB 1
`define SRBC_PRE_EXT_MSB 3
`define SRBC_SLEEP_STAT_BIT 7
`define SRBC_TPC_LSB 0
`define SRBC_TPC_MSB 1
`define SRBC_WAR_IDLE_BIT 0
`define SRBC_CAS_LSB 0
`define SRBC_CAS_MSB 2
`define SRBC_OPE_BIT 0
// ==========================================================
// Reset values
`define SRBC_RST_REFRESH_CTRL 8'h00
`define SRBC_RST_DRAM_ACCESS 8'h00
`define SRBC_RST_BUS_CTRL 8'h00
`define SRBC_RST_CAS 3'h7
`define SRBC_RST_OPE 1'b1
// ==========================================================
// Timing counts in states
`define SRBC_AREF_STATES 4'h4
`define SRBC_ACCESS_STATES 2'h2
// ==========================================================
// SDRAM commands
`define SRBC_CMD_NOP 3'h0
`define SRBC_CMD_AUTO 3'h1
`define SRBC_CMD_SELF 3'h2
`define SRBC_CMD_EXIT 3'h3
// ==========================================================
// AXI responses
`define SRBC_RESP_OKAY 2'h0
`define SRBC_RESP_SLVERR 2'h2
`endif

// ===== src/srbc_bus_seq.v
`timescale 1ns/1ps
`include "srbc_regs.vh"
module srbc_bus_seq (
    input wire mclk,
    input wire arst_n,
    input wire hold,
    input wire war_idle_en,
    input wire [2:0] cas_sel,
    input wire ext_valid,
    input wire ext_write,
    output reg ext_done,
    output reg busy,
    output reg cyc_active,
    output reg cyc_write,
    output reg idle_cycle,
    output reg lat_state
);
    localparam S_IDLE = 3'd0;
    localparam S_GAP = 3'd1;
    localparam S_ACC = 3'd2;
    localparam S_LAT = 3'd3;

    reg [2:0] state_reg;
    reg [1:0] cnt_reg;
    reg last_read_reg;
    wire [1:0] lat_states;
    wire start;

    // Codes 000..011 give 0..3 latency states; reserved codes clamp to 3
    assign lat_states = cas_sel[2] ? 2'h3 : cas_sel[1:0]; // RULE_12
    assign start = (state_reg == S_IDLE) && ext_valid && !hold && !ext_done;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
            cnt_reg <= 2'h0;
            last_read_reg <= 1'b0;
            ext_done <= 1'b0;
            busy <= 1'b0;
            cyc_active <= 1'b0;
            cyc_write <= 1'b0;
            idle_cycle <= 1'b0;
            lat_state <= 1'b0;
        end else begin
            ext_done <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        cyc_write <= ext_write;
                        if (ext_write && last_read_reg && war_idle_en) begin
                            state_reg <= S_GAP; // RULE_10
                            idle_cycle <= 1'b1;
                        end else begin
                            state_reg <= S_ACC; // RULE_11
                            cyc_active <= 1'b1;
                            cnt_reg <= `SRBC_ACCESS_STATES - 2'h1;
                        end
                    end else begin
                        // Done cycle still counts as directly after the read
                        if (!ext_done) begin
                            last_read_reg <= 1'b0;
                        end
                        busy <= 1'b0;
                    end
                end
                S_GAP: begin
                    idle_cycle <= 1'b0;
                    cyc_active <= 1'b1;
                    cnt_reg <= `SRBC_ACCESS_STATES - 2'h1;
                    state_reg <= S_ACC;
                end
                S_ACC: begin
                    if (cnt_reg != 2'h0) begin
                        cnt_reg <= cnt_reg - 2'h1;
                    end else if (!cyc_write && lat_states != 2'h0) begin
                        state_reg <= S_LAT; // RULE_12
                        lat_state <= 1'b1;
                        cnt_reg <= lat_states - 2'h1;
                    end else begin
                        state_reg <= S_IDLE;
                        cyc_active <= 1'b0;
                        ext_done <= 1'b1;
                        last_read_reg <= !cyc_write;
                    end
                end
                S_LAT: begin
                    if (cnt_reg != 2'h0) begin
                        cnt_reg <= cnt_reg - 2'h1;
                    end else begin
                        state_reg <= S_IDLE;
                        lat_state <= 1'b0;
                        cyc_active <= 1'b0;
                        ext_done <= 1'b1;
                        last_read_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // srbc_bus_seq

// ===== src/srbc_ctrl.v
// What this block does
// RULE_01 - Self-refresh in standby only when the refresh mode enable bit is 1.
// RULE_02 - Entering software standby with self-refresh selected issues the self-refresh command.
// RULE_03 - Leaving standby clears the sleep refresh status and exits self-refresh automatically.
// RULE_04 - A pending auto refresh completes before self-refresh is entered.
// RULE_05 - No refresh timing or refresh address is driven during self-refresh.
// RULE_06 - Software keeps the output port enable bit set while using self-refresh.
// RULE_07 - Precharge after self-refresh exit is extended by 1 to 7 states.
// RULE_08 - Normal precharge from the two-bit field still applies, extension added.
// RULE_09 - Software picks the extension to meet the memory exit-to-command interval.
// RULE_10 - Write after read with idle bit 1 inserts one idle cycle first.
// RULE_11 - Write after read with idle bit 0 starts immediately.
// RULE_12 - CAS latency codes 000..011 insert 0..3 latency states; others reserved.
`timescale 1ns/1ps
`include "srbc_regs.vh"
module srbc_ctrl (
    input wire mclk,
    input wire arst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire standby_req,
    output reg standby_ack,
    input wire refresh_req,
    output reg [2:0] sdram_cmd,
    output reg sdram_cke,
    output reg [11:0] refresh_addr,
    output reg refresh_addr_oe,
    output reg pins_oe,
    output reg sdram_ready,
    input wire ext_valid,
    input wire ext_write,
    output wire ext_done,
    output wire bus_cycle_active,
    output wire bus_cycle_write,
    output wire bus_idle_cycle,
    output wire bus_latency_state
);
    localparam R_IDLE = 3'd0;
    localparam R_AREF = 3'd1;
    localparam R_SELF = 3'd2;
    localparam R_PRE = 3'd3;
    localparam R_STBY = 3'd4;
    localparam [7:0] RST_RC = `SRBC_RST_REFRESH_CTRL;

    // ======================================================
    // Registers
    reg refresh_mode_enable;
    reg [2:0] post_refresh_precharge_extend;
    reg sleep_refresh_status;
    reg [1:0] precharge_cycle_count;
    reg write_after_read_idle;
    reg [2:0] cas_latency_select;
    reg output_port_enable;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg aw_full_reg;
    reg w_full_reg;
    reg [2:0] rstate_reg;
    reg [3:0] rcnt_reg;
    reg pending_reg;
    reg [31:0] rdata_next;
    reg rdec_ok;
    reg wdec_ok;
    wire seq_busy;
    wire do_write;
    wire pend_take;
    wire [3:0] pre_states;

    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    // Normal precharge states plus extension after self-refresh exit
    assign pre_states = {2'h0, precharge_cycle_count} + 4'h1 +
                        {1'b0, post_refresh_precharge_extend}; // RULE_07 RULE_08

    // ======================================================
    // Register decode
    always @* begin
        rdata_next = 32'h0;
        rdec_ok = 1'b1;
        case (s_axi_araddr)
            `SRBC_OFS_REFRESH_CTRL: begin
                rdata_next[`SRBC_RFSH_EN_BIT] = refresh_mode_enable;
                rdata_next[`SRBC_PRE_EXT_MSB:`SRBC_PRE_EXT_LSB] = post_refresh_precharge_extend;
                rdata_next[`SRBC_SLEEP_STAT_BIT] = sleep_refresh_status;
            end
            `SRBC_OFS_DRAM_ACCESS: begin
                rdata_next[`SRBC_TPC_MSB:`SRBC_TPC_LSB] = precharge_cycle_count;
            end
            `SRBC_OFS_BUS_CTRL: begin
                rdata_next[`SRBC_WAR_IDLE_BIT] = write_after_read_idle;
            end
            `SRBC_OFS_WAIT_CTRL_B: begin
                rdata_next[`SRBC_CAS_MSB:`SRBC_CAS_LSB] = cas_latency_select;
            end
            `SRBC_OFS_STANDBY_CTRL: begin
                rdata_next[`SRBC_OPE_BIT] = output_port_enable;
            end
            `SRBC_OFS_STATUS: begin
                rdata_next[2:0] = rstate_reg;
                rdata_next[3] = pending_reg;
                rdata_next[4] = seq_busy;
            end
            default: begin
                rdec_ok = 1'b0;
            end
        endcase
    end

    always @* begin
        case (aw_addr_reg)
            `SRBC_OFS_REFRESH_CTRL: wdec_ok = 1'b1;
            `SRBC_OFS_DRAM_ACCESS: wdec_ok = 1'b1;
            `SRBC_OFS_BUS_CTRL: wdec_ok = 1'b1;
            `SRBC_OFS_WAIT_CTRL_B: wdec_ok = 1'b1;
            `SRBC_OFS_STANDBY_CTRL: wdec_ok = 1'b1;
            `SRBC_OFS_STATUS: wdec_ok = 1'b1;
            default: wdec_ok = 1'b0;
        endcase
    end

    // ======================================================
    // AXI4-Lite slave
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SRBC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `SRBC_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            refresh_mode_enable <= RST_RC[`SRBC_RFSH_EN_BIT];
            post_refresh_precharge_extend <= 3'h0;
            precharge_cycle_count <= 2'h0;
            write_after_read_idle <= 1'b0;
            cas_latency_select <= `SRBC_RST_CAS;
            output_port_enable <= `SRBC_RST_OPE;
        end else begin
            if (!aw_full_reg && !s_axi_bvalid && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_full_reg && !s_axi_bvalid && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wdec_ok ? `SRBC_RESP_OKAY : `SRBC_RESP_SLVERR;
                if (w_strb_reg[0]) begin
                    case (aw_addr_reg)
                        `SRBC_OFS_REFRESH_CTRL: begin
                            refresh_mode_enable <= w_data_reg[`SRBC_RFSH_EN_BIT];
                            post_refresh_precharge_extend <=
                                w_data_reg[`SRBC_PRE_EXT_MSB:`SRBC_PRE_EXT_LSB];
                        end
                        `SRBC_OFS_DRAM_ACCESS: begin
                            precharge_cycle_count <= w_data_reg[`SRBC_TPC_MSB:`SRBC_TPC_LSB];
                        end
                        `SRBC_OFS_BUS_CTRL: begin
                            write_after_read_idle <= w_data_reg[`SRBC_WAR_IDLE_BIT];
                        end
                        `SRBC_OFS_WAIT_CTRL_B: begin
                            cas_latency_select <= w_data_reg[`SRBC_CAS_MSB:`SRBC_CAS_LSB];
                        end
                        `SRBC_OFS_STANDBY_CTRL: begin
                            output_port_enable <= w_data_reg[`SRBC_OPE_BIT];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_next;
                s_axi_rresp <= rdec_ok ? `SRBC_RESP_OKAY : `SRBC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ======================================================
    // Refresh and standby sequencer
    assign pend_take = (rstate_reg == R_IDLE || rstate_reg == R_AREF) &&
                       pending_reg && rcnt_reg == 4'h0 && !seq_busy;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstate_reg <= R_IDLE;
            rcnt_reg <= 4'h0;
            pending_reg <= 1'b0;
            sleep_refresh_status <= 1'b0;
            standby_ack <= 1'b0;
            sdram_cmd <= `SRBC_CMD_NOP;
            sdram_cke <= 1'b1;
            refresh_addr <= 12'h0;
            refresh_addr_oe <= 1'b0;
            pins_oe <= 1'b1;
            sdram_ready <= 1'b1;
        end else begin
            // New request wins over the clear of the pending flag
            pending_reg <= refresh_req | (pending_reg & !pend_take);
            sdram_cmd <= `SRBC_CMD_NOP;
            refresh_addr_oe <= 1'b0;
            // Pins stay driven in standby only while output_port_enable is 1, so CKE holds low
            pins_oe <= output_port_enable | !standby_ack; // RULE_06
            if (rcnt_reg != 4'h0) begin
                rcnt_reg <= rcnt_reg - 4'h1;
            end
            case (rstate_reg)
                R_IDLE: begin
                    if (pend_take) begin
                        sdram_cmd <= `SRBC_CMD_AUTO;
                        refresh_addr_oe <= 1'b1;
                        refresh_addr <= refresh_addr + 12'h1;
                        rcnt_reg <= `SRBC_AREF_STATES;
                        rstate_reg <= R_AREF;
                    end else if (standby_req && !seq_busy && !pending_reg && !refresh_req) begin // RULE_04
                        standby_ack <= 1'b1;
                        if (refresh_mode_enable) begin
                            sdram_cmd <= `SRBC_CMD_SELF; // RULE_01 RULE_02
                            sdram_cke <= 1'b0;
                            sleep_refresh_status <= 1'b1;
                            sdram_ready <= 1'b0;
                            rstate_reg <= R_SELF;
                        end else begin
                            rstate_reg <= R_STBY; // RULE_01
                        end
                    end
                end
                R_AREF: begin
                    // Standby waits here until the auto refresh ends
                    if (rcnt_reg == 4'h1) begin
                        rstate_reg <= R_IDLE; // RULE_04
                    end
                end
                R_SELF: begin
                    // Memory times its own refresh; address stays undriven
                    refresh_addr_oe <= 1'b0; // RULE_05
                    if (!standby_req) begin
                        sdram_cmd <= `SRBC_CMD_EXIT; // RULE_03
                        sdram_cke <= 1'b1;
                        sleep_refresh_status <= 1'b0; // RULE_03
                        standby_ack <= 1'b0;
                        rcnt_reg <= pre_states; // RULE_07 RULE_08
                        rstate_reg <= R_PRE;
                    end
                end
                R_PRE: begin
                    if (rcnt_reg == 4'h1) begin
                        sdram_ready <= 1'b1;
                        rstate_reg <= R_IDLE;
                    end
                end
                R_STBY: begin
                    if (!standby_req) begin
                        standby_ack <= 1'b0;
                        rstate_reg <= R_IDLE;
                    end
                end
                default: begin
                    rstate_reg <= R_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // External bus cycle sequencer
    srbc_bus_seq u_seq (
        .mclk(mclk),
        .arst_n(arst_n),
        .hold(rstate_reg != R_IDLE || pending_reg),
        .war_idle_en(write_after_read_idle),
        .cas_sel(cas_latency_select),
        .ext_valid(ext_valid),
        .ext_write(ext_write),
        .ext_done(ext_done),
        .busy(seq_busy),
        .cyc_active(bus_cycle_active),
        .cyc_write(bus_cycle_write),
        .idle_cycle(bus_idle_cycle),
        .lat_state(bus_latency_state)
    );
endmodule // srbc_ctrl

// ===== tb/srbc_asserts.sv
`timescale 1ns/1ps
`include "srbc_regs.vh"
// ========================================
// Port checks of the refresh and bus controller
module srbc_asserts (
    input wire mclk,
    input wire arst_n,
    input wire standby_req,
    input wire [2:0] sdram_cmd,
    input wire sdram_cke,
    input wire refresh_addr_oe,
    input wire sdram_ready,
    input wire ext_done,
    input wire bus_cycle_active,
    input wire bus_cycle_write,
    input wire bus_idle_cycle,
    input wire bus_latency_state
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    a_self_on_sleep: assert property (sdram_cmd == `SRBC_CMD_SELF |-> standby_req && $past(standby_req))
        else $error("self without standby");
    a_self_drops_cke: assert property (sdram_cmd == `SRBC_CMD_SELF |=> !sdram_cke)
        else $error("cke high in self");
    a_no_refresh_sleep: assert property (!sdram_cke |-> !refresh_addr_oe && sdram_cmd != `SRBC_CMD_AUTO)
        else $error("refresh in self");
    a_exit_on_wake: assert property ($fell(standby_req) && !sdram_cke |-> ##[0:4] sdram_cmd == `SRBC_CMD_EXIT)
        else $error("no exit");
    a_exit_raises_cke: assert property (sdram_cmd == `SRBC_CMD_EXIT |-> ##1 sdram_cke)
        else $error("cke low after exit");
    a_post_exit_pre: assert property (sdram_cmd == `SRBC_CMD_EXIT |-> !sdram_ready ##1 !sdram_ready ##[1:14] sdram_ready)
        else $error("bad precharge");
    a_idle_then_write: assert property (bus_idle_cycle |=> bus_cycle_active && bus_cycle_write)
        else $error("no write after idle");
    a_idle_single: assert property (bus_idle_cycle |-> !bus_cycle_active ##1 !bus_idle_cycle)
        else $error("long idle");
    a_latency_reads: assert property (bus_latency_state |-> !bus_cycle_write)
        else $error("latency in write");
    a_latency_max: assert property (bus_latency_state [*3] |=> !bus_latency_state)
        else $error("latency over 3");
    a_done_pulse: assert property (ext_done |=> !ext_done)
        else $error("long done");
endmodule // srbc_asserts
bind srbc_ctrl srbc_asserts i_asserts (.mclk, .arst_n, .standby_req, .sdram_cmd, .sdram_cke,
    .refresh_addr_oe, .sdram_ready, .ext_done, .bus_cycle_active, .bus_cycle_write,
    .bus_idle_cycle, .bus_latency_state);

// ===== tb/srbc_sdram_model.sv
`timescale 1ns/1ps
`include "srbc_regs.vh"
// ========================================
// Memory side: sleep state and illegal commands
module srbc_sdram_model (
    input wire mclk,
    input wire arst_n,
    input wire [2:0] sdram_cmd,
    input wire [11:0] refresh_addr,
    input wire refresh_addr_oe,
    output logic in_self,
    output int bad_cnt,
    output int auto_cnt
);
    logic [11:0] last_addr;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            in_self <= 1'b0;
            bad_cnt <= 0;
            auto_cnt <= 0;
            last_addr <= 12'h000;
        end else begin
            if (sdram_cmd == `SRBC_CMD_AUTO) begin
                // Rows step by one from refresh to refresh
                if (auto_cnt > 0 && refresh_addr !== last_addr + 12'h001) bad_cnt <= bad_cnt + 1;
                auto_cnt <= auto_cnt + 1;
                last_addr <= refresh_addr;
            end
            if (sdram_cmd == `SRBC_CMD_SELF) begin
                if (in_self) bad_cnt <= bad_cnt + 1;
                in_self <= 1'b1;
            end
            if (sdram_cmd == `SRBC_CMD_EXIT) begin
                if (!in_self) bad_cnt <= bad_cnt + 1;
                in_self <= 1'b0;
            end
            if (in_self && (refresh_addr_oe || sdram_cmd == `SRBC_CMD_AUTO)) bad_cnt <= bad_cnt + 1;
        end
    end
endmodule // srbc_sdram_model

// ===== tb/srbc_ctrl_tb.sv
`timescale 1ns/1ps
`include "srbc_regs.vh"
module srbc_ctrl_tb;
    // ========================================
    // Stimulus, design and memory model
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic standby_req = 1'b0, refresh_req = 1'b0, ext_valid = 1'b0, ext_write = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] sdram_cmd;
    wire [11:0] refresh_addr;
    wire standby_ack, sdram_cke, refresh_addr_oe, pins_oe, sdram_ready, ext_done, in_self;
    wire bus_cycle_active, bus_cycle_write, bus_idle_cycle, bus_latency_state;
    int bad_cnt, auto_cnt, lat_base, lat, err_count = 0, num_checks = 0;
    int wd[2];
    int rst_val[6] = '{0, 0, 0, 7, 1, 0};
    int mask[4] = '{15, 3, 1, 7};
    int tpcs[3] = '{3, 0, 2};
    logic [1:0] ok = `SRBC_RESP_OKAY, slverr = `SRBC_RESP_SLVERR;
    logic [2:0] cmd_q[$];
    always #12.5 mclk = ~mclk;
    srbc_ctrl i_dut (.*);
    srbc_sdram_model i_mem (.*);
    always @(posedge mclk) if (sdram_cmd !== `SRBC_CMD_NOP) cmd_q.push_back(sdram_cmd);
    // ========================================
    // Compare, report and bus tasks
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Counts: %0d checks, %0d mismatches", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic timed_out(input string what);
        chk_w(0, 1, {what, " timeout"});
        give_verdict();
    endtask
    // Write when wr, else read; d is write data or expected read data
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 40);
        if (n >= 40) timed_out("bus");
        chk_w(wr ? s_axi_bresp : s_axi_rresp, er, "resp");
        if (!wr) chk_w(s_axi_rdata, d, "rdata");
        {s_axi_bready, s_axi_rready} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic wait_ack(input logic lvl);
        int n = 0;
        while (standby_ack !== lvl && n < 60) begin
            @(posedge mclk);
            n++;
        end
        if (standby_ack !== lvl) timed_out("standby acknowledge");
    endtask
    // One sleep and wake; lat = edges from exit command to ready
    task automatic self_run(input int tpc, input int ext, input bit aref, output int lat);
        int n = 0;
        axi(1, `SRBC_OFS_DRAM_ACCESS, tpc, ok);
        axi(1, `SRBC_OFS_REFRESH_CTRL, ext * 2 + 1, ok);
        cmd_q.delete();
        refresh_req <= aref;
        standby_req <= 1'b1;
        @(posedge mclk);
        refresh_req <= 1'b0;
        wait_ack(1'b1);
        @(posedge mclk);
        chk_w(cmd_q.size(), aref ? 2 : 1, "cmd count");
        chk_w(cmd_q[0], aref ? `SRBC_CMD_AUTO : `SRBC_CMD_SELF, "first cmd");
        chk_w(cmd_q[aref], `SRBC_CMD_SELF, "sleep cmd");
        axi(0, `SRBC_OFS_REFRESH_CTRL, 128 + ext * 2 + 1, ok);
        chk_w({sdram_cke, in_self}, 1, "asleep");
        standby_req <= 1'b0;
        while (sdram_cmd !== `SRBC_CMD_EXIT && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) timed_out("exit");
        lat = 0;
        while (sdram_ready !== 1'b1 && lat < 30) begin
            @(posedge mclk);
            lat++;
        end
        wait_ack(1'b0);
        axi(0, `SRBC_OFS_REFRESH_CTRL, ext * 2 + 1, ok);
    endtask
    // A read directly followed by a write
    task automatic war_pair(input int war, input int code);
        int n = 0, phase = 0, lt = 0, idl = 0, t0 = 0;
        axi(1, `SRBC_OFS_BUS_CTRL, war, ok);
        axi(1, `SRBC_OFS_WAIT_CTRL_B, code, ok);
        ext_write <= 1'b0;
        ext_valid <= 1'b1;
        while (phase < 2 && n < 80) begin
            @(posedge mclk);
            n++;
            lt += bus_latency_state === 1'b1;
            idl += bus_idle_cycle === 1'b1;
            if (ext_done === 1'b1) begin
                phase++;
                t0 = n - t0;
                if (phase == 1) ext_write <= 1'b1;
                else ext_valid <= 1'b0;
            end
        end
        if (phase < 2) timed_out("access");
        chk_w(lt, code > 3 ? 3 : code, "latency");
        chk_w(idl, war, "idle");
        wd[war] = t0;
    endtask
    // ========================================
    // Main sequence
    initial begin
        logic [31:0] d;
        void'($urandom(62));
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 6; i++) axi(0, 4 * i, rst_val[i], ok);
        axi(0, 8'h18, 0, slverr);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            axi(1, 4 * i, d, ok);
            axi(0, 4 * i, d & mask[i], ok);
        end
        axi(1, `SRBC_OFS_STATUS, $urandom, ok);
        axi(0, `SRBC_OFS_STATUS, 0, ok);
        axi(1, 8'h1c, $urandom, slverr);
        axi(1, `SRBC_OFS_STANDBY_CTRL, 1, ok);
        $display("test registers done");
        axi(1, `SRBC_OFS_REFRESH_CTRL, 0, ok);
        cmd_q.delete();
        standby_req <= 1'b1;
        wait_ack(1'b1);
        repeat (8) @(posedge mclk);
        chk_w(cmd_q.size(), 0, "cmds, no self");
        chk_w(sdram_cke, 1, "cke in standby");
        standby_req <= 1'b0;
        wait_ack(1'b0);
        $display("test plain standby done");
        self_run(0, 1, 1'b1, lat_base);
        for (int i = 0; i < 3; i++) begin
            d = (i == 2) ? $urandom_range(7, 1) : 7 - 4 * i;
            self_run(tpcs[i], d, 1'b0, lat);
            chk_w(lat - lat_base, tpcs[i] + d - 1, "precharge");
        end
        chk_w(pins_oe, 1, "pins enabled");
        $display("test self-refresh done");
        for (int w = 0; w < 2; w++) for (int c = 0; c < 8; c++) war_pair(w, c);
        chk_w(wd[1] - wd[0], 1, "write delay");
        chk_w(bad_cnt, 0, "memory faults");
        chk_w(auto_cnt, 1, "auto refreshes");
        $display("test bus cycles done");
        give_verdict();
    end
endmodule // srbc_ctrl_tb
